// File: core/iat_map.svh
`ifndef IAT_MAP_SVH
`define IAT_MAP_SVH

// ====================================================================
// Register byte offsets (AXI4-Lite, one aligned word each)
// ====================================================================
`define IAT_OFS_CTRL      8'h00
`define IAT_OFS_CMD       8'h04
`define IAT_OFS_TRIG_SEL  8'h08
`define IAT_OFS_TRIG_CFG  8'h0C
`define IAT_OFS_BURST     8'h10
`define IAT_OFS_EXPOSURE  8'h14
`define IAT_OFS_PERIOD    8'h18
`define IAT_OFS_READOUT   8'h1C
`define IAT_OFS_STATUS    8'h20

// ====================================================================
// Field positions
// ====================================================================
`define IAT_CTRL_CONT     0
`define IAT_CTRL_STD      1
`define IAT_CMD_START     0
`define IAT_CMD_STOP      1
`define IAT_CMD_SWTRIG    2
`define IAT_CFG_GATE      0
`define IAT_CFG_LINE      1
`define IAT_CFG_WIDTH     2

// ====================================================================
// Reset values and timing counts (clock cycles at 25 MHz)
// ====================================================================
`define IAT_RST_BURST     16'h0001
`define IAT_RST_EXPOSURE  32'h0000_03E8
`define IAT_RST_PERIOD    32'h0001_86A0
`define IAT_RST_READOUT   32'h0000_0400
`define IAT_RESP_OKAY     2'b00
`define IAT_RESP_SLVERR   2'b10

`endif

// File: core/iat_pkg.sv
package iat_pkg;

  // ==================================================================
  // Acquisition status codes
  // ==================================================================
  typedef enum logic [2:0] {
    IAT_IDLE    = 3'b000,
    IAT_WAIT_AS = 3'b001,
    IAT_WAIT_FS = 3'b010,
    IAT_EXPOSE  = 3'b011,
    IAT_READOUT = 3'b100
  } iat_state_t;

  // Per-trigger settings: gating on, line 1 source, width exposure
  typedef struct packed {
    logic width;
    logic line;
    logic gate;
  } iat_cfg_t;

  // ==================================================================
  // AXI4-Lite carriers
  // ==================================================================
  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } iat_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } iat_axi_rsp_t;

  // Camera-side outputs
  typedef struct packed {
    logic exposing;
    logic reading;
    logic acq_active;
    logic frame_done;
  } iat_cam_t;

endpackage : iat_pkg

// File: core/iat_ctrl.sv
// Operation
// - No frame is acquired before the host issues an acquisition start.
// - Single-frame setting: one frame per start, then the start expires.
// - Continuous setting: start stays active until a stop command.
// - After a stop, frames need a fresh start command.
// - Stop during a frame lets it finish; otherwise it stops at once.
// - Acquisition-start gating off: start triggers are made internally.
// - Gating on: begin waiting for acquisition start, frame triggers ignored.
// - Acquisition-start trigger moves to waiting for frame start.
// - Count accepted frame triggers; at burst count wait for start again.
// - Accepted frame trigger starts exposure and readout, then waits again.
// - Frame-start gating off: internal frame triggers at programmed period.
// - Frame-start gating on: one exposure per applied frame trigger.
// - Frame triggers outside the frame-wait status are discarded.
// - Software trigger command gives one occurrence of selected trigger.
// - Each rising pulse on input line 1 is one trigger occurrence.
// - Mode, source and software trigger apply to selected trigger only.
// - Software frame triggers use the programmed exposure time.
// - Hardware frame triggers: timed or trigger-width exposure.
// - Compatibility mode: no start trigger; frame trigger takes its name.
// - Reset brings the block up in compatibility mode.
`timescale 1ns/1ps
`default_nettype none
`include "iat_map.svh"

module iat_ctrl #(
  parameter int BURST_W = 16
) (
  // Clock, reset, enable
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  ce,
  // AXI4-Lite register bus
  input  wire iat_pkg::iat_axi_req_t axi_req,
  output var  iat_pkg::iat_axi_rsp_t axi_rsp,
  // Hardware trigger input line 1
  input  wire logic                  line1,
  // Camera status towards sensor logic
  output var  iat_pkg::iat_cam_t     cam
);
  import iat_pkg::*;

  // ==================================================================
  // Elaboration checks
  // ==================================================================
  if (BURST_W < 1 || BURST_W > 16) begin : g_chk
    $error("BURST_W must lie in 1..16");
  end

  // ==================================================================
  // Whole state of the block
  // ==================================================================
  typedef struct packed {
    // Bus slave
    logic               awready;
    logic               wready;
    logic               arready;
    logic               aw_got;
    logic [7:0]         awaddr;
    logic               w_got;
    logic [31:0]        wdata;
    logic [3:0]         wstrb;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               rvalid;
    logic [31:0]        rdata;
    logic [1:0]         rresp;
    // Software-visible settings
    logic               cont;
    logic               std;
    logic               sel_fs;
    iat_cfg_t           as_cfg;
    iat_cfg_t           fs_cfg;
    logic [BURST_W-1:0] burst;
    logic [31:0]        exposure;
    logic [31:0]        period;
    logic [31:0]        readout;
    // Acquisition core
    iat_state_t         state;
    logic               active;
    logic               stop_pend;
    logic [BURST_W-1:0] frm_cnt;
    logic [31:0]        tmr;
    logic [31:0]        per_cnt;
    logic               line_prev;
    logic               frame_done;
    logic               exposing;
    logic               reading;
  } iat_st_t;

  iat_st_t st_r;
  iat_st_t st_nxt;

  // Byte-lane merge for a written word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] dat,
                                        input logic [3:0]  stb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (stb[i]) begin
        res[8*i +: 8] = dat[8*i +: 8];
      end
    end
    return res;
  endfunction : merge

  // ==================================================================
  // Next-state logic
  // ==================================================================
  logic               wr_fire;
  logic [31:0]        wval;
  logic               cmd_start;
  logic               cmd_stop;
  logic               cmd_sw;
  logic               tgt_fs;
  logic               as_on;
  logic               rise;
  logic               as_evt;
  logic               fs_evt;
  logic               width_mode;
  logic               in_frame;
  logic               rd_ok;
  logic [31:0]        rd_val;
  logic [BURST_W-1:0] burst_w;
  iat_cfg_t           cfg_new;

  always_comb begin
    st_nxt     = st_r;
    st_nxt.frame_done = 1'b0;
    wval       = 32'h0000_0000;
    cmd_start  = 1'b0;
    cmd_stop   = 1'b0;
    cmd_sw     = 1'b0;
    rd_ok      = 1'b1;
    rd_val     = 32'h0000_0000;
    burst_w    = st_r.burst;
    cfg_new    = st_r.fs_cfg;

    // Write address and data are taken in either order
    if (axi_req.awvalid && st_r.awready) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && st_r.wready) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = axi_req.wdata;
      st_nxt.wstrb = axi_req.wstrb;
    end
    if (st_r.bvalid && axi_req.bready) begin
      st_nxt.bvalid = 1'b0;
    end

    // Compatibility mode steers every trigger write to frame start
    tgt_fs  = !st_r.std || st_r.sel_fs;
    wr_fire = st_r.aw_got && st_r.w_got && !st_r.bvalid;
    if (wr_fire) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got  = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = `IAT_RESP_OKAY;
      case (st_r.awaddr)
        `IAT_OFS_CTRL: begin
          wval = merge({30'h0, st_r.std, st_r.cont}, st_r.wdata,
                       st_r.wstrb);
          st_nxt.cont = wval[`IAT_CTRL_CONT];
          st_nxt.std  = wval[`IAT_CTRL_STD];
        end
        `IAT_OFS_CMD: begin
          if (st_r.wstrb[0]) begin
            cmd_start = st_r.wdata[`IAT_CMD_START];
            cmd_stop  = st_r.wdata[`IAT_CMD_STOP];
            cmd_sw    = st_r.wdata[`IAT_CMD_SWTRIG];
          end
        end
        `IAT_OFS_TRIG_SEL: begin
          if (st_r.wstrb[0]) begin
            st_nxt.sel_fs = st_r.wdata[0];
          end
        end
        `IAT_OFS_TRIG_CFG: begin
          if (st_r.wstrb[0]) begin
            cfg_new = iat_cfg_t'(st_r.wdata[2:0]);
            if (tgt_fs) begin
              st_nxt.fs_cfg = cfg_new;
            end else begin
              st_nxt.as_cfg = cfg_new;
            end
          end
        end
        `IAT_OFS_BURST: begin
          wval = merge(32'(st_r.burst), st_r.wdata, st_r.wstrb);
          st_nxt.burst = wval[BURST_W-1:0];
        end
        `IAT_OFS_EXPOSURE: begin
          st_nxt.exposure = merge(st_r.exposure, st_r.wdata, st_r.wstrb);
        end
        `IAT_OFS_PERIOD: begin
          st_nxt.period = merge(st_r.period, st_r.wdata, st_r.wstrb);
        end
        `IAT_OFS_READOUT: begin
          st_nxt.readout = merge(st_r.readout, st_r.wdata, st_r.wstrb);
        end
        `IAT_OFS_STATUS: begin
          // Read-only; the write is acknowledged and dropped
        end
        default: begin
          st_nxt.bresp = `IAT_RESP_SLVERR;
        end
      endcase
    end

    // Read decode; unmapped addresses answer SLVERR with zero data
    case (axi_req.araddr)
      `IAT_OFS_CTRL:     rd_val = {30'h0, st_r.std, st_r.cont};
      `IAT_OFS_CMD:      rd_val = 32'h0000_0000;
      `IAT_OFS_TRIG_SEL: rd_val = {31'h0, st_r.sel_fs};
      `IAT_OFS_TRIG_CFG: rd_val = tgt_fs ? {29'h0, st_r.fs_cfg}
                                         : {29'h0, st_r.as_cfg};
      `IAT_OFS_BURST:    rd_val = 32'(st_r.burst);
      `IAT_OFS_EXPOSURE: rd_val = st_r.exposure;
      `IAT_OFS_PERIOD:   rd_val = st_r.period;
      `IAT_OFS_READOUT:  rd_val = st_r.readout;
      `IAT_OFS_STATUS:   rd_val = {16'(st_r.frm_cnt), 11'h0, st_r.state,
                                   st_r.stop_pend, st_r.active};
      default:           rd_ok  = 1'b0;
    endcase
    if (axi_req.arvalid && st_r.arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata  = rd_ok ? rd_val : 32'h0000_0000;
      st_nxt.rresp  = rd_ok ? `IAT_RESP_OKAY : `IAT_RESP_SLVERR;
    end
    if (st_r.rvalid && axi_req.rready) begin
      st_nxt.rvalid = 1'b0;
    end

    // Trigger sources; line 1 counts on its rising edge only
    rise  = line1 && !st_r.line_prev;
    st_nxt.line_prev = line1;
    as_on = st_r.std && st_r.as_cfg.gate;
    // Start trigger made internally when its gating is off
    if (!as_on) begin
      as_evt = 1'b1;
    end else if (st_r.as_cfg.line) begin
      as_evt = rise;
    end else begin
      as_evt = cmd_sw && !tgt_fs;
    end
    // Frame trigger from the period timer when its gating is off
    if (!st_r.fs_cfg.gate) begin
      fs_evt = st_r.per_cnt + 32'd1 >= st_r.period;
    end else if (st_r.fs_cfg.line) begin
      fs_evt = rise;
    end else begin
      fs_evt = cmd_sw && tgt_fs;
    end
    // Width mode only exists for a hardware-sourced frame trigger
    width_mode = st_r.fs_cfg.gate && st_r.fs_cfg.line
                 && st_r.fs_cfg.width;
    in_frame   = (st_r.state == IAT_EXPOSE)
                 || (st_r.state == IAT_READOUT);

    // Period timer runs from one frame start to the next
    if (st_r.per_cnt != 32'hFFFF_FFFF) begin
      st_nxt.per_cnt = st_r.per_cnt + 32'd1;
    end

    // Acquisition status machine
    unique case (st_r.state)
      IAT_IDLE: begin
        // Nothing happens until a start command arrives
      end
      IAT_WAIT_AS: begin
        // Frame triggers are ignored here
        if (as_evt) begin
          st_nxt.state   = IAT_WAIT_FS;
          st_nxt.frm_cnt = '0;
          st_nxt.per_cnt = 32'h0000_0000;
        end
      end
      IAT_WAIT_FS: begin
        if (fs_evt) begin
          st_nxt.state   = IAT_EXPOSE;
          st_nxt.frm_cnt = st_r.frm_cnt + 1'b1;
          st_nxt.tmr     = 32'h0000_0000;
          st_nxt.per_cnt = 32'h0000_0000;
        end
      end
      IAT_EXPOSE: begin
        // Triggers arriving now are simply not looked at
        st_nxt.tmr = st_r.tmr + 32'd1;
        if (width_mode ? !line1
                       : (st_r.tmr + 32'd1 >= st_r.exposure)) begin
          st_nxt.state = IAT_READOUT;
          st_nxt.tmr   = 32'h0000_0000;
        end
      end
      IAT_READOUT: begin
        st_nxt.tmr = st_r.tmr + 32'd1;
        if (st_r.tmr + 32'd1 >= st_r.readout) begin
          st_nxt.frame_done = 1'b1;
          st_nxt.tmr        = 32'h0000_0000;
          if (!st_r.cont || st_r.stop_pend) begin
            // Single frame expires the start; a held stop ends here
            st_nxt.state     = IAT_IDLE;
            st_nxt.active    = 1'b0;
            st_nxt.stop_pend = 1'b0;
          end else if (as_on && st_r.frm_cnt >= burst_w) begin
            st_nxt.state = IAT_WAIT_AS;
          end else begin
            st_nxt.state = IAT_WAIT_FS;
          end
        end
      end
      default: begin
        // Unused codes fall back to idle
        st_nxt.state = IAT_IDLE;
      end
    endcase

    // Commands override the machine; stop wins over a same-word start
    if (cmd_start && !cmd_stop) begin
      st_nxt.active    = 1'b1;
      st_nxt.stop_pend = 1'b0;
      if (st_r.state == IAT_IDLE) begin
        st_nxt.state = IAT_WAIT_AS;
      end
    end
    if (cmd_stop) begin
      // A frame that ends at this edge is no longer in progress
      if (in_frame && (st_nxt.state == IAT_EXPOSE
                       || st_nxt.state == IAT_READOUT)) begin
        st_nxt.stop_pend = 1'b1;
      end else begin
        st_nxt.state     = IAT_IDLE;
        st_nxt.active    = 1'b0;
        st_nxt.stop_pend = 1'b0;
      end
    end

    // Ready flags follow from the next state, so they leave a flop
    st_nxt.awready = !st_nxt.aw_got && !st_nxt.bvalid;
    st_nxt.wready  = !st_nxt.w_got && !st_nxt.bvalid;
    st_nxt.arready = !st_nxt.rvalid;
    // Phase flags registered so the camera outputs leave a flop
    st_nxt.exposing = (st_nxt.state == IAT_EXPOSE);
    st_nxt.reading  = (st_nxt.state == IAT_READOUT);
  end

  // ==================================================================
  // State register; reset starts in compatibility mode
  // ==================================================================
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r          <= '0;
      st_r.awready  <= 1'b1;
      st_r.wready   <= 1'b1;
      st_r.arready  <= 1'b1;
      st_r.std      <= 1'b0;
      st_r.burst    <= BURST_W'(`IAT_RST_BURST);
      st_r.exposure <= `IAT_RST_EXPOSURE;
      st_r.period   <= `IAT_RST_PERIOD;
      st_r.readout  <= `IAT_RST_READOUT;
      st_r.state    <= IAT_IDLE;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  // ==================================================================
  // Outputs, all taken from the state register
  // ==================================================================
  assign axi_rsp.awready = st_r.awready;
  assign axi_rsp.wready  = st_r.wready;
  assign axi_rsp.bvalid  = st_r.bvalid;
  assign axi_rsp.bresp   = st_r.bresp;
  assign axi_rsp.arready = st_r.arready;
  assign axi_rsp.rvalid  = st_r.rvalid;
  assign axi_rsp.rdata   = st_r.rdata;
  assign axi_rsp.rresp   = st_r.rresp;

  assign cam.exposing    = st_r.exposing;
  assign cam.reading     = st_r.reading;
  assign cam.acq_active  = st_r.active;
  assign cam.frame_done  = st_r.frame_done;

endmodule : iat_ctrl

`default_nettype wire

// File: sim/iat_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Bus and frame sequencing checker
module iat_ctrl_chk (
  // Clock, reset, enable
  input wire logic                  aclk,
  input wire logic                  aresetn,
  input wire logic                  ce,
  // Register bus
  input wire iat_pkg::iat_axi_req_t axi_req,
  input wire iat_pkg::iat_axi_rsp_t axi_rsp,
  // Trigger line and camera status
  input wire logic                  line1,
  input wire iat_pkg::iat_cam_t     cam
);
  import iat_pkg::*;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Address and data taken at one edge, answer two edges later
  sequence wr_taken;
    ce && axi_req.awvalid && axi_rsp.awready &&
      axi_req.wvalid && axi_rsp.wready;
  endsequence
  sequence wr_answer;
    ##2 axi_rsp.bvalid;
  endsequence
  // Exposure ends into readout, readout ends into done pulse
  sequence exp_end;
    $fell(cam.exposing);
  endsequence
  sequence read_end;
    $fell(cam.reading);
  endsequence

  chk_wr_answer: assert property (wr_taken |-> wr_answer)
    else $error("write response late or missing");
  chk_rd_answer: assert property (
    ce && axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
    else $error("read response late or missing");
  chk_b_stands: assert property (
    axi_rsp.bvalid && !axi_req.bready |=>
      axi_rsp.bvalid && $stable(axi_rsp.bresp))
    else $error("write response dropped early");
  chk_r_stands: assert property (
    axi_rsp.rvalid && !axi_req.rready |=>
      axi_rsp.rvalid && $stable(axi_rsp.rdata))
    else $error("read data dropped early");
  // Reset leaves bus ready and camera quiet
  chk_reset_quiet: assert property ($rose(aresetn) |->
    axi_rsp.awready && axi_rsp.arready && !axi_rsp.bvalid &&
    !axi_rsp.rvalid && cam == '0)
    else $error("outputs not at reset values");
  chk_exp_active: assert property (
    $rose(cam.exposing) |-> cam.acq_active)
    else $error("exposure without acquisition start");
  chk_exp_read: assert property (exp_end |-> cam.reading)
    else $error("exposure not followed by readout");
  chk_read_done: assert property (read_end |-> cam.frame_done)
    else $error("readout end without done pulse");
  // A frozen clock enable holds the pulse, so only running edges count
  chk_done_pulse: assert property (
    ce && cam.frame_done |=> !cam.frame_done)
    else $error("done pulse longer than one cycle");
  chk_one_phase: assert property (
    !(cam.exposing && cam.reading))
    else $error("exposing and reading together");
endmodule : iat_ctrl_chk

bind iat_ctrl iat_ctrl_chk u_chk (
  .aclk    (aclk),
  .aresetn (aresetn),
  .ce      (ce),
  .axi_req (axi_req),
  .axi_rsp (axi_rsp),
  .line1   (line1),
  .cam     (cam)
);

`default_nettype wire

// File: sim/iat_trig_src.sv
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// External trigger source on input line 1
module iat_trig_src (
  // Clock
  input  wire logic aclk,
  // Trigger line towards the block
  output var  logic line1
);
  initial line1 = 1'b0;

  // High for w edges, then a rest so frames are not overrun
  task automatic pulse(input int w, input int gap);
    @(posedge aclk);
    line1 <= 1'b1;
    repeat (w) @(posedge aclk);
    line1 <= 1'b0;
    repeat (gap) @(posedge aclk);
  endtask : pulse
endmodule : iat_trig_src

`default_nettype wire

// File: sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "iat_map.svh"

// ============================================================
// Testbench top
module tb_top;
  import iat_pkg::*;

  logic         aclk;
  logic         aresetn;
  logic         ce;
  iat_axi_req_t req;
  iat_axi_rsp_t rsp;
  wire logic    line1;
  iat_cam_t     cam;
  logic [31:0]  dat_c;
  logic [1:0]   rsp_c;
  int           bad_count;
  int           n_checks;
  int           n_exp;
  int           n_done;
  int           run_e;
  int           len_e;
  int           run_r;
  int           len_r;

  iat_ctrl #(.BURST_W(16)) DUT (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .axi_req(req),
    .axi_rsp(rsp), .line1(line1), .cam(cam));
  iat_trig_src src (.aclk(aclk), .line1(line1));

  // 25 MHz clock
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  // Frame monitor: phase lengths in edges, frame counts
  always @(posedge aclk) begin
    if (cam.exposing === 1'b1) run_e++;
    else if (run_e > 0) begin
      len_e = run_e;
      run_e = 0;
      n_exp++;
    end
    if (cam.reading === 1'b1) run_r++;
    else if (run_r > 0) begin
      len_r = run_r;
      run_r = 0;
    end
    if (cam.frame_done === 1'b1) n_done++;
  end

  // ============================================================
  // Bus master, compare and wait helpers
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= d;
    req.wstrb   <= 4'hF;
    req.bready  <= 1'b1;
    // Waits for the answer; only the watchdog ends a hang
    do begin
      @(posedge aclk);
      if (req.awvalid && rsp.awready === 1'b1) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready === 1'b1) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    r = rsp.bresp;
    req.bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (req.arvalid && rsp.arready === 1'b1) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
  endtask : rd

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a, dat_c, rsp_c);
    cmp(dat_c, e);
  endtask : rchk

  task automatic chk_state(input iat_state_t s);
    rd(`IAT_OFS_STATUS, dat_c, rsp_c);
    cmp(32'(dat_c[4:2]), 32'(s));
  endtask : chk_state

  // Bounded wait for the exposing level
  task automatic wait_exp();
    for (int i = 0; i < 200 && cam.exposing !== 1'b1; i++)
      @(posedge aclk);
  endtask : wait_exp

  // ============================================================
  // Scenarios
  task automatic t_regs();
    rchk(`IAT_OFS_CTRL, 32'h0000_0000);
    rchk(`IAT_OFS_CMD, 32'h0000_0000);
    rchk(`IAT_OFS_TRIG_SEL, 32'h0000_0000);
    rchk(`IAT_OFS_BURST, 32'(`IAT_RST_BURST));
    rchk(`IAT_OFS_EXPOSURE, `IAT_RST_EXPOSURE);
    rchk(`IAT_OFS_PERIOD, `IAT_RST_PERIOD);
    rchk(`IAT_OFS_READOUT, `IAT_RST_READOUT);
    rchk(`IAT_OFS_STATUS, 32'h0000_0000);
    rd(8'h24, dat_c, rsp_c);
    cmp(32'(rsp_c), 32'(`IAT_RESP_SLVERR));
    cmp(dat_c, 32'h0000_0000);
    wr(8'h24, 32'h0000_0001, rsp_c);
    cmp(32'(rsp_c), 32'(`IAT_RESP_SLVERR));
    // Short counts keep frames a few cycles long
    wr(`IAT_OFS_EXPOSURE, 32'h0000_0004, rsp_c);
    wr(`IAT_OFS_READOUT, 32'h0000_0004, rsp_c);
    wr(`IAT_OFS_PERIOD, 32'h0000_0014, rsp_c);
    rchk(`IAT_OFS_EXPOSURE, 32'h0000_0004);
  endtask : t_regs

  // Triggers before any start are dropped
  task automatic t_idle();
    wr(`IAT_OFS_TRIG_CFG, 32'h0000_0001, rsp_c);
    wr(`IAT_OFS_CMD, 32'h0000_0004, rsp_c);
    wr(`IAT_OFS_TRIG_CFG, 32'h0000_0003, rsp_c);
    src.pulse(2, 20);
    cmp(32'(n_exp), 0);
    chk_state(IAT_IDLE);
  endtask : t_idle

  // Single frame by software, with a clock-enable freeze inside
  task automatic t_single();
    wr(`IAT_OFS_TRIG_CFG, 32'h0000_0001, rsp_c);
    wr(`IAT_OFS_CMD, 32'h0000_0001, rsp_c);
    chk_state(IAT_WAIT_FS);
    wr(`IAT_OFS_CMD, 32'h0000_0004, rsp_c);
    wait_exp();
    ce <= 1'b0;
    repeat (5) @(posedge aclk);
    ce <= 1'b1;
    repeat (30) @(posedge aclk);
    cmp(32'(len_e), 32'd9);
    cmp(32'(len_r), 32'd4);
    cmp(32'(n_done), 1);
    cmp(32'(cam.acq_active), 0);
    wr(`IAT_OFS_CMD, 32'h0000_0004, rsp_c);
    repeat (30) @(posedge aclk);
    cmp(32'(n_exp), 1);
  endtask : t_single

  // Continuous by line 1: close trigger dropped, stop mid-frame
  task automatic t_cont();
    int b;
    b = n_exp;
    wr(`IAT_OFS_CTRL, 32'h0000_0001, rsp_c);
    wr(`IAT_OFS_TRIG_CFG, 32'h0000_0003, rsp_c);
    wr(`IAT_OFS_CMD, 32'h0000_0001, rsp_c);
    repeat (3) src.pulse(1, 30);
    cmp(32'(n_exp - b), 3);
    src.pulse(1, 2);
    src.pulse(1, 30);
    cmp(32'(n_exp - b), 4);
    b = n_done;
    src.pulse(1, 0);
    wait_exp();
    wr(`IAT_OFS_CMD, 32'h0000_0002, rsp_c);
    repeat (30) @(posedge aclk);
    cmp(32'(n_done - b), 1);
    chk_state(IAT_IDLE);
    b = n_exp;
    src.pulse(1, 30);
    cmp(32'(n_exp - b), 0);
  endtask : t_cont

  // Trigger-width exposure, then stop with no frame running
  task automatic t_width();
    wr(`IAT_OFS_TRIG_CFG, 32'h0000_0007, rsp_c);
    wr(`IAT_OFS_CMD, 32'h0000_0001, rsp_c);
    src.pulse(10, 30);
    cmp(32'(len_e), 32'd10);
    wr(`IAT_OFS_CMD, 32'h0000_0002, rsp_c);
    chk_state(IAT_IDLE);
  endtask : t_width

  // Standard mode: gated start by software, burst of two frames
  task automatic t_burst();
    int b;
    b = n_exp;
    wr(`IAT_OFS_CTRL, 32'h0000_0003, rsp_c);
    wr(`IAT_OFS_BURST, 32'h0000_0002, rsp_c);
    wr(`IAT_OFS_TRIG_SEL, 32'h0000_0001, rsp_c);
    wr(`IAT_OFS_TRIG_CFG, 32'h0000_0003, rsp_c);
    wr(`IAT_OFS_TRIG_SEL, 32'h0000_0000, rsp_c);
    wr(`IAT_OFS_TRIG_CFG, 32'h0000_0001, rsp_c);
    wr(`IAT_OFS_CMD, 32'h0000_0001, rsp_c);
    chk_state(IAT_WAIT_AS);
    src.pulse(1, 30);
    cmp(32'(n_exp - b), 0);
    for (int k = 1; k <= 2; k++) begin
      wr(`IAT_OFS_CMD, 32'h0000_0004, rsp_c);
      chk_state(IAT_WAIT_FS);
      repeat (3) src.pulse(1, 30);
      cmp(32'(n_exp - b), 32'(2 * k));
      chk_state(IAT_WAIT_AS);
    end
    // Start trigger from line 1 this time
    wr(`IAT_OFS_TRIG_CFG, 32'h0000_0003, rsp_c);
    src.pulse(1, 2);
    chk_state(IAT_WAIT_FS);
    wr(`IAT_OFS_TRIG_SEL, 32'h0000_0001, rsp_c);
    rchk(`IAT_OFS_TRIG_CFG, 32'h0000_0003);
    wr(`IAT_OFS_TRIG_SEL, 32'h0000_0000, rsp_c);
    wr(`IAT_OFS_TRIG_CFG, 32'h0000_0000, rsp_c);
    wr(`IAT_OFS_CMD, 32'h0000_0002, rsp_c);
    wr(`IAT_OFS_CMD, 32'h0000_0001, rsp_c);
    chk_state(IAT_WAIT_FS);
    wr(`IAT_OFS_CMD, 32'h0000_0002, rsp_c);
  endtask : t_burst

  // Free-running frames from the internal period of 20 cycles
  task automatic t_free();
    int b;
    wr(`IAT_OFS_CTRL, 32'h0000_0001, rsp_c);
    wr(`IAT_OFS_TRIG_CFG, 32'h0000_0000, rsp_c);
    b = n_done;
    wr(`IAT_OFS_CMD, 32'h0000_0001, rsp_c);
    repeat (200) @(posedge aclk);
    wr(`IAT_OFS_CMD, 32'h0000_0002, rsp_c);
    repeat (30) @(posedge aclk);
    b = n_done - b;
    cmp(32'(b >= 9 && b <= 12), 1);
  endtask : t_free

  // ============================================================
  // Verdict and end of run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test

  // Main sequence after a two-cycle reset
  initial begin
    aresetn = 1'b0;
    ce      = 1'b1;
    req     = '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_idle();
    t_single();
    t_cont();
    t_width();
    t_burst();
    t_free();
    stop_test();
  end

  // Watchdog well beyond the thousand or so cycles needed
  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    $display("FAIL %0t watchdog expired", $time);
    stop_test();
  end
endmodule : tb_top

`default_nettype wire
